// ---- verilog/spaf_framer.sv ----
// Serial packetizer for transparent mode and API frame parser and builder.
`timescale 1ns/100ps
module spaf_framer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration
  input wire logic api_mode_en,
  input wire logic spi_sel,
  input wire logic command_mode,
  input wire logic [7:0] packetization_timeout,
  input wire logic [15:0] guard_silence_time,
  input wire logic [7:0] escape_sequence_character,
  // Serial bytes from the host
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  // Serial bytes to the host
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  // Packets released toward the radio
  output logic rf_tx_valid,
  output logic [7:0] rf_tx_data,
  output logic rf_tx_last,
  output logic rf_tx_cmd,
  input wire logic rf_tx_ready,
  // Payload received by the radio
  input wire logic rf_rx_valid,
  input wire logic [7:0] rf_rx_data,
  input wire logic rf_rx_last,
  input wire logic [7:0] rf_rx_len,
  input wire logic [15:0] rf_rx_src,
  output logic rf_rx_ready,
  // Status, responses and events to report
  input wire logic tx_status_valid,
  input wire logic [7:0] tx_status_frame_id,
  input wire logic [7:0] tx_status_code,
  input wire logic cmd_resp_valid,
  input wire logic [7:0] cmd_resp_frame_id,
  input wire logic [7:0] cmd_resp_status,
  input wire logic evt_reset,
  input wire logic evt_assoc,
  input wire logic evt_disassoc,
  // Indications
  output logic api_active,
  output logic escape_detected,
  output logic rx_overflow
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [6:0] us_div;
  logic [9:0] ms_div;
  logic [7:0] buffer_mem [spaf_pkg::MAX_PAYLOAD];
  logic [spaf_pkg::CNT_W-1:0] fill_cnt, send_len, esc_base;
  logic [spaf_pkg::IDX_W-1:0] rd_idx;
  logic [7:0] idle_us, in_sum;
  logic [15:0] silence_ms;
  logic [1:0] esc_cnt;
  spaf_pkg::spaf_parse_t pstate;
  logic [8:0] frame_len;
  logic us_tick, ms_tick, draining, t_acc, a_acc, wr_en, buf_full, esc_match, guard_met;
  logic rel_full, rel_to, rel_esc, esc_stale, frame_ok, drain_done;

  // SPI always forces framing, so transparent mode cannot run on it.
  assign api_active = api_mode_en | spi_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Microsecond and millisecond enables for the idle and guard timers.
  assign us_tick = (us_div == 7'(spaf_pkg::US_TICK_CYCLES - 1));
  assign ms_tick = us_tick && (ms_div == 10'(spaf_pkg::MS_TICK_US - 1));

  always_ff @(posedge core_clk) begin
    if (rst || us_tick) begin
      us_div <= 7'h00;
    end else begin
      us_div <= us_div + 7'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || ms_tick) begin
      ms_div <= 10'h000;
    end else if (us_tick) begin
      ms_div <= ms_div + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial input acceptance.
  assign buf_full = draining || (fill_cnt == spaf_pkg::MAX_CNT);
  assign t_acc = ser_rx_valid && !api_active && !command_mode && !buf_full;
  assign a_acc = ser_rx_valid && api_active && !draining;
  assign wr_en = t_acc || (a_acc && pstate == spaf_pkg::P_DATA);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_overflow <= 1'b0;
    end else begin
      rx_overflow <= ser_rx_valid && (api_active ? draining : buf_full && !command_mode);
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      buffer_mem[fill_cnt[spaf_pkg::IDX_W-1:0]] <= ser_rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Idle and guard timers; idle restarts on each byte taken in transparent mode, guard on each byte seen there.
  always_ff @(posedge core_clk) begin
    if (rst || t_acc || rel_full || rel_to || rel_esc) begin
      idle_us <= 8'h00;
    end else if (us_tick && idle_us != 8'hff) begin
      idle_us <= idle_us + 8'h01;
    end
  end

  // Guard silence is also counted in command mode so the next sequence can follow.
  always_ff @(posedge core_clk) begin
    if (rst || (ser_rx_valid && !api_active)) begin
      silence_ms <= 16'h0000;
    end else if (ms_tick && silence_ms != 16'hffff) begin
      silence_ms <= silence_ms + 16'h0001;
    end
  end

  assign guard_met = (silence_ms >= guard_silence_time);
  assign esc_match = (ser_rx_data == escape_sequence_character) &&
                     ((esc_cnt == 2'h0 && guard_met) || (esc_cnt != 2'h0 && esc_cnt != 2'h3));

  // Escape characters sit in the buffer until the trailing guard proves the sequence.
  always_ff @(posedge core_clk) begin
    if (rst || rel_full || rel_esc || esc_stale) begin
      esc_cnt <= 2'h0;
    end else if (t_acc) begin
      esc_cnt <= esc_match ? esc_cnt + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      esc_base <= '0;
    end else if (t_acc && esc_match && esc_cnt == 2'h0) begin
      esc_base <= fill_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Release triggers for transparent mode.
  assign rel_full = !api_active && !draining && fill_cnt == spaf_pkg::MAX_CNT;
  assign rel_esc = !api_active && !draining && !t_acc && esc_cnt == 2'h3 && guard_met;
  assign esc_stale = !t_acc && esc_cnt != 2'h0 && esc_cnt != 2'h3 && guard_met;
  assign rel_to = !api_active && !draining && !rel_full && fill_cnt != '0 &&
                  esc_cnt == 2'h0 && !t_acc &&
                  (packetization_timeout == 8'h00 ||
                   idle_us >= packetization_timeout);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      escape_detected <= 1'b0;
    end else begin
      escape_detected <= rel_esc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host frame parser: delimiter, length, frame data, checksum.
  assign frame_ok = (in_sum + ser_rx_data == spaf_pkg::API_CSUM_OK) &&
                    (buffer_mem[0] == spaf_pkg::TYPE_TX_REQ ||
                     buffer_mem[0] == spaf_pkg::TYPE_CMD);

  always_ff @(posedge core_clk) begin
    if (rst || !api_active) begin
      pstate <= spaf_pkg::P_DELIM;
    end else if (a_acc) begin
      unique case (pstate)
        spaf_pkg::P_DELIM: begin
          if (ser_rx_data == spaf_pkg::API_DELIM) begin
            pstate <= spaf_pkg::P_LENH;
          end
        end
        spaf_pkg::P_LENH: begin
          pstate <= spaf_pkg::P_LENL;
        end
        spaf_pkg::P_LENL: begin
          if ({frame_len[8], ser_rx_data} == 9'h000 ||
              {frame_len[8], ser_rx_data} > 9'(spaf_pkg::MAX_PAYLOAD)) begin
            pstate <= spaf_pkg::P_DELIM;
          end else begin
            pstate <= spaf_pkg::P_DATA;
          end
        end
        spaf_pkg::P_DATA: begin
          if (9'(fill_cnt) + 9'h001 == frame_len) begin
            pstate <= spaf_pkg::P_CSUM;
          end
        end
        spaf_pkg::P_CSUM: begin
          pstate <= spaf_pkg::P_DELIM;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_len <= 9'h000;
      in_sum <= 8'h00;
    end else if (a_acc) begin
      if (pstate == spaf_pkg::P_LENH) begin
        frame_len <= {|ser_rx_data, 8'h00};
      end else if (pstate == spaf_pkg::P_LENL) begin
        frame_len <= {frame_len[8], ser_rx_data};
        in_sum <= 8'h00;
      end else if (pstate == spaf_pkg::P_DATA) begin
        in_sum <= in_sum + ser_rx_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer fill count and the drain toward the radio.
  assign drain_done = rf_tx_valid && rf_tx_ready && rf_tx_last;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fill_cnt <= '0;
      draining <= 1'b0;
      send_len <= '0;
      rf_tx_cmd <= 1'b0;
    end else if (drain_done) begin
      fill_cnt <= '0;
      draining <= 1'b0;
    end else if (rel_esc) begin
      fill_cnt <= esc_base;
      send_len <= esc_base;
      draining <= (esc_base != '0);
      rf_tx_cmd <= 1'b0;
    end else if (rel_full || rel_to) begin
      send_len <= fill_cnt;
      draining <= 1'b1;
      rf_tx_cmd <= 1'b0;
    end else if (a_acc && pstate == spaf_pkg::P_CSUM) begin
      send_len <= fill_cnt;
      draining <= frame_ok;
      rf_tx_cmd <= (buffer_mem[0] == spaf_pkg::TYPE_CMD);
      if (!frame_ok) begin
        fill_cnt <= '0;
      end
    end else if (a_acc && pstate == spaf_pkg::P_LENL) begin
      fill_cnt <= '0;
    end else if (wr_en) begin
      fill_cnt <= fill_cnt + 7'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !draining) begin
      rd_idx <= '0;
    end else if (rf_tx_valid && rf_tx_ready) begin
      rd_idx <= rd_idx + 6'h01;
    end
  end

  assign rf_tx_valid = draining;
  assign rf_tx_data = buffer_mem[rd_idx];
  assign rf_tx_last = draining && (7'(rd_idx) + 7'h01 == send_len);

  ////////////////////////////////////////////////////////////////////////////////
  // Frames and raw bytes toward the host.
  spaf_pkg::spaf_out_t ostate;
  spaf_pkg::spaf_kind_t okind;
  logic [2:0] hdr_idx, ev_pend, hdr_last;
  logic [7:0] f_a, f_b, f_c, out_sum, st_id, st_code, cr_id, cr_code, next_byte;
  logic [8:0] f_len;
  logic st_pend, cr_pend, load, take;

  function automatic logic [7:0] spaf_hdr_byte(input logic [2:0] idx, input logic [8:0] len,
                                               input logic [7:0] a, input logic [7:0] b,
                                               input logic [7:0] c);
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      3'h0: r = spaf_pkg::API_DELIM;
      3'h1: r = {7'h00, len[8]};
      3'h2: r = len[7:0];
      3'h3: r = a;
      3'h4: r = b;
      default: r = c;
    endcase
    return r;
  endfunction

  assign load = !ser_tx_valid || ser_tx_ready;
  assign hdr_last = (okind == spaf_pkg::K_EVENT) ? spaf_pkg::HDR_LAST_EVENT :
                    (okind == spaf_pkg::K_RX) ? spaf_pkg::HDR_LAST_RX : spaf_pkg::HDR_LAST_STATUS;

  always_comb begin
    next_byte = 8'h00;
    take = 1'b0;
    rf_rx_ready = 1'b0;
    unique case (ostate)
      spaf_pkg::O_IDLE: begin
        rf_rx_ready = !api_active && load;
        take = !api_active && load && rf_rx_valid;
        next_byte = rf_rx_data;
      end
      spaf_pkg::O_HDR: begin
        take = load;
        next_byte = spaf_hdr_byte(hdr_idx, f_len, f_a, f_b, f_c);
      end
      spaf_pkg::O_BODY: begin
        rf_rx_ready = load;
        take = load && rf_rx_valid;
        next_byte = rf_rx_data;
      end
      spaf_pkg::O_CSUM: begin
        take = load;
        next_byte = spaf_pkg::API_CSUM_OK - out_sum;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ser_tx_valid <= 1'b0;
      ser_tx_data <= 8'h00;
    end else if (load) begin
      ser_tx_valid <= take;
      ser_tx_data <= next_byte;
    end
  end

  // Reports arriving while their earlier copy is being sent are kept; the set wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_pend <= 1'b0;
      cr_pend <= 1'b0;
      ev_pend <= 3'h0;
      st_id <= 8'h00;
      st_code <= 8'h00;
      cr_id <= 8'h00;
      cr_code <= 8'h00;
    end else begin
      if (ostate == spaf_pkg::O_IDLE && api_active && ev_pend == 3'h0) begin
        cr_pend <= cr_pend && st_pend;
        st_pend <= 1'b0;
      end
      if (tx_status_valid) begin
        st_pend <= 1'b1;
        st_id <= tx_status_frame_id;
        st_code <= tx_status_code;
      end
      if (cmd_resp_valid) begin
        cr_pend <= 1'b1;
        cr_id <= cmd_resp_frame_id;
        cr_code <= cmd_resp_status;
      end
      ev_pend <= (ostate == spaf_pkg::O_IDLE && api_active ? ev_pend & (ev_pend - 3'h1) : ev_pend)
                 | {evt_disassoc, evt_assoc, evt_reset};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ostate <= spaf_pkg::O_IDLE;
      okind <= spaf_pkg::K_RX;
      hdr_idx <= 3'h0;
      f_a <= 8'h00;
      f_b <= 8'h00;
      f_c <= 8'h00;
      f_len <= 9'h000;
      out_sum <= 8'h00;
    end else begin
      unique case (ostate)
        spaf_pkg::O_IDLE: begin
          hdr_idx <= 3'h0;
          out_sum <= 8'h00;
          if (api_active) begin
            if (ev_pend != 3'h0) begin
              ostate <= spaf_pkg::O_HDR;
              okind <= spaf_pkg::K_EVENT;
              f_len <= spaf_pkg::LEN_EVENT;
              f_a <= spaf_pkg::TYPE_EVENT;
              f_b <= ev_pend[0] ? spaf_pkg::EVT_RESET :
                     ev_pend[1] ? spaf_pkg::EVT_ASSOC : spaf_pkg::EVT_DISASSOC;
            end else if (st_pend || cr_pend) begin
              ostate <= spaf_pkg::O_HDR;
              okind <= st_pend ? spaf_pkg::K_STATUS : spaf_pkg::K_CMD;
              f_len <= spaf_pkg::LEN_STATUS;
              f_a <= st_pend ? spaf_pkg::TYPE_TX_STATUS : spaf_pkg::TYPE_CMD_RESP;
              f_b <= st_pend ? st_id : cr_id;
              f_c <= st_pend ? st_code : cr_code;
            end else if (rf_rx_valid) begin
              ostate <= spaf_pkg::O_HDR;
              okind <= spaf_pkg::K_RX;
              f_len <= spaf_pkg::LEN_RX_HDR + {1'b0, rf_rx_len};
              f_a <= spaf_pkg::TYPE_RX_DATA;
              f_b <= rf_rx_src[15:8];
              f_c <= rf_rx_src[7:0];
            end
          end
        end
        spaf_pkg::O_HDR: begin
          if (take) begin
            hdr_idx <= hdr_idx + 3'h1;
            if (hdr_idx >= spaf_pkg::HDR_SUM_START) begin
              out_sum <= out_sum + next_byte;
            end
            if (hdr_idx == hdr_last) begin
              ostate <= (okind == spaf_pkg::K_RX) ? spaf_pkg::O_BODY : spaf_pkg::O_CSUM;
            end
          end
        end
        spaf_pkg::O_BODY: begin
          if (take) begin
            out_sum <= out_sum + next_byte;
            if (rf_rx_last) begin
              ostate <= spaf_pkg::O_CSUM;
            end
          end
        end
        spaf_pkg::O_CSUM: begin
          if (take) begin
            ostate <= spaf_pkg::O_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ---- verilog/spaf_pkg.sv ----
// Constants, frame codes and timing figures shared by the serial packetizer and API framer.
package spaf_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int US_TICK_NS = 1000;
  localparam int US_TICK_CYCLES = (US_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_TICK_US = 1000;

  localparam int MAX_PAYLOAD = 64;
  localparam int IDX_W = 6;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] MAX_CNT = 7'h40;

  localparam logic [7:0] API_DELIM = 8'h7e;
  localparam logic [7:0] API_CSUM_OK = 8'hff;
  localparam logic [7:0] TYPE_TX_REQ = 8'h10;
  localparam logic [7:0] TYPE_CMD = 8'h08;
  localparam logic [7:0] TYPE_RX_DATA = 8'h90;
  localparam logic [7:0] TYPE_TX_STATUS = 8'h8b;
  localparam logic [7:0] TYPE_CMD_RESP = 8'h88;
  localparam logic [7:0] TYPE_EVENT = 8'h8a;
  localparam logic [7:0] EVT_RESET = 8'h00;
  localparam logic [7:0] EVT_ASSOC = 8'h02;
  localparam logic [7:0] EVT_DISASSOC = 8'h03;

  localparam logic [8:0] LEN_RX_HDR = 9'h003;
  localparam logic [8:0] LEN_STATUS = 9'h003;
  localparam logic [8:0] LEN_EVENT = 9'h002;
  localparam logic [2:0] HDR_LAST_RX = 3'h5;
  localparam logic [2:0] HDR_LAST_STATUS = 3'h5;
  localparam logic [2:0] HDR_LAST_EVENT = 3'h4;
  localparam logic [2:0] HDR_SUM_START = 3'h3;

  typedef enum logic [4:0] {
    P_DELIM = 5'b00001,
    P_LENH = 5'b00010,
    P_LENL = 5'b00100,
    P_DATA = 5'b01000,
    P_CSUM = 5'b10000
  } spaf_parse_t;

  typedef enum logic [3:0] {
    O_IDLE = 4'b0001,
    O_HDR = 4'b0010,
    O_BODY = 4'b0100,
    O_CSUM = 4'b1000
  } spaf_out_t;

  typedef enum logic [1:0] {
    K_RX = 2'h0,
    K_STATUS = 2'h1,
    K_CMD = 2'h2,
    K_EVENT = 2'h3
  } spaf_kind_t;

endpackage

// ---- bench/spaf_framer_props.sv ----
// Port-level checks for the serial packetizer and API framer.
`timescale 1ns/100ps
module spaf_framer_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration
  input wire logic api_mode_en,
  input wire logic spi_sel,
  input wire logic command_mode,
  input wire logic [7:0] packetization_timeout,
  input wire logic [7:0] escape_sequence_character,
  // Serial side
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  // Radio side
  input wire logic rf_tx_valid,
  input wire logic [7:0] rf_tx_data,
  input wire logic rf_tx_last,
  input wire logic rf_tx_ready,
  input wire logic rf_rx_valid,
  input wire logic [7:0] rf_rx_data,
  input wire logic rf_rx_ready,
  // Events and indications
  input wire logic evt_reset,
  input wire logic api_active,
  input wire logic rx_overflow
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Bytes already taken in the packet that is draining.
  logic [6:0] pkt_cnt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pkt_cnt <= 7'h00;
    end else if (rf_tx_valid && rf_tx_ready) begin
      pkt_cnt <= rf_tx_last ? 7'h00 : pkt_cnt + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_api_sel;
    api_active == (api_mode_en || spi_sel);
  endproperty
  a_api_sel: assert property (p_api_sel) else $error("framing not forced by link select");
  // The two idle cycles before the byte rule out a release already under way.
  property p_zero_to;
    !api_active && !command_mode && packetization_timeout == 8'h00 && ser_rx_valid &&
      ser_rx_data != escape_sequence_character && !rf_tx_valid &&
      !$past(ser_rx_valid) && !$past(ser_rx_valid, 2) |-> ##2 rf_tx_valid;
  endproperty
  a_zero_to: assert property (p_zero_to) else $error("byte not released at zero timeout");
  property p_drain_hold;
    rf_tx_valid && !rf_tx_ready |=> rf_tx_valid && $stable(rf_tx_data) && $stable(rf_tx_last);
  endproperty
  a_drain_hold: assert property (p_drain_hold) else $error("radio byte lost while stalled");
  property p_ser_hold;
    ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data);
  endproperty
  a_ser_hold: assert property (p_ser_hold) else $error("serial byte lost while stalled");
  property p_pkt_len;
    rf_tx_valid && rf_tx_ready |-> pkt_cnt < 7'h40;
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("radio packet too long");
  property p_pass;
    !api_active && rf_rx_valid && rf_rx_ready |=> ser_tx_valid && ser_tx_data == $past(rf_rx_data);
  endproperty
  a_pass: assert property (p_pass) else $error("radio byte not forwarded unchanged");
  property p_ovf;
    rx_overflow |-> $past(ser_rx_valid);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without a serial byte");
  property p_cmd_quiet;
    command_mode && !api_active && ser_rx_valid |=> !rx_overflow;
  endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("command byte flagged");
  property p_evt;
    api_active && evt_reset |-> ##[1:300] ser_tx_valid && ser_tx_data == 8'h7e;
  endproperty
  a_evt: assert property (p_evt) else $error("event frame not started");

  c_full: cover property (rf_tx_valid && rf_tx_ready && rf_tx_last && pkt_cnt == 7'h3f);
  c_ovf: cover property (rx_overflow);
  c_evt: cover property (api_active && evt_reset);
endmodule

bind spaf_framer spaf_framer_props spaf_framer_props_i (.*);

// ---- bench/spaf_host_model.sv ----
// Behavioural host that sends serial bytes and frames and collects serial output.
`timescale 1ns/100ps
module spaf_host_model (
  // Clock
  input wire logic core_clk,
  // Serial link
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  output logic ser_tx_ready
);
  logic [7:0] tx_q[$];
  logic [7:0] got[$];
  logic slow = 1'b0;

  initial begin
    ser_rx_valid = 1'b0;
    ser_rx_data = 8'ha5;
  end

  // A slow host takes a byte only every other cycle.
  always @(negedge core_clk) ser_tx_ready <= slow ? !ser_tx_ready : 1'b1;

  always @(posedge core_clk) begin
    if (ser_tx_valid && ser_tx_ready) begin
      got.push_back(ser_tx_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // An idle data line shows the inverse of the last byte, never a stale copy.
  task automatic send(input int gap);
    while (tx_q.size() > 0) begin
      @(negedge core_clk);
      ser_rx_valid = 1'b1;
      ser_rx_data = tx_q.pop_front();
      if (gap > 0) begin
        @(negedge core_clk);
        ser_rx_valid = 1'b0;
        ser_rx_data = ~ser_rx_data;
        repeat (gap - 1) @(negedge core_clk);
      end
    end
    if (ser_rx_valid) begin
      @(negedge core_clk);
      ser_rx_valid = 1'b0;
      ser_rx_data = ~ser_rx_data;
    end
  endtask

  // Sends one delimited frame; bad spoils the checksum on purpose.
  task automatic frame(input logic [7:0] typ, input logic [7:0] b1, input logic [7:0] b2,
                       input logic bad);
    logic [7:0] f [7];
    f = '{8'h7e, 8'h00, 8'h03, typ, b1, b2, (8'hff - typ - b1 - b2) ^ {7'h00, bad}};
    foreach (f[i]) tx_q.push_back(f[i]);
    send(0);
  endtask
endmodule

// ---- bench/spaf_framer_test.sv ----
// Self-checking bench for the serial packetizer and API framer.
`timescale 1ns/100ps
module spaf_framer_test;
  typedef struct packed {
    logic [2:0] kind;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] sum;
  } spaf_row_t;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic api_mode_en, spi_sel, command_mode, rf_tx_ready, rf_rx_valid, rf_rx_last;
  logic tx_status_valid, cmd_resp_valid, evt_reset, evt_assoc, evt_disassoc;
  logic [7:0] tx_status_frame_id, tx_status_code, cmd_resp_frame_id, cmd_resp_status;
  logic [7:0] packetization_timeout, rf_rx_data, rf_rx_len;
  logic [15:0] rf_rx_src;
  logic [15:0] guard_silence_time = 16'hffff;
  logic [7:0] escape_sequence_character = 8'h2b;
  logic ser_rx_valid, ser_tx_valid, ser_tx_ready, rf_tx_valid, rf_tx_last, rf_tx_cmd;
  logic rf_rx_ready, api_active, escape_detected, rx_overflow;
  logic [7:0] ser_rx_data, ser_tx_data, rf_tx_data;
  logic [7:0] ex[$];
  logic [8:0] rq[$];
  logic [63:0] fv;
  int miscompares = 0;
  int total_checks = 0;
  int ovf_cnt = 0;
  spaf_row_t rows [5] = '{'{3'h0, 8'h00, 8'h00, 8'h75}, '{3'h1, 8'h02, 8'h00, 8'h73},
    '{3'h2, 8'h03, 8'h00, 8'h72}, '{3'h3, 8'h01, 8'h21, 8'h52}, '{3'h4, 8'h05, 8'h01, 8'h71}};

  spaf_framer spaf_framer_i (.*);
  spaf_host_model spaf_host_model_i (.*);

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (rx_overflow === 1'b1) ovf_cnt++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic set_ex(input logic [63:0] v, input int n);
    ex.delete();
    for (int i = 0; i < n; i++) ex.push_back(v[63 - 8 * i -: 8]);
  endtask

  task automatic rf_take(input logic cmd);
    rq.delete();
    @(negedge core_clk);
    rf_tx_ready = 1'b1;
    for (int k = 0; k < 2000 && rq.size() < ex.size(); k++) begin
      if (rf_tx_valid === 1'b1) begin
        check(rf_tx_cmd, cmd);
        rq.push_back({rf_tx_last, rf_tx_data});
      end
      @(negedge core_clk);
    end
    rf_tx_ready = 1'b0;
    check(16'(rq.size()), 16'(ex.size()));
    foreach (rq[i]) check(rq[i], {1'(i == ex.size() - 1), ex[i]});
  endtask

  task automatic host_expect;
    for (int k = 0; k < 800 && spaf_host_model_i.got.size() < ex.size(); k++)
      @(negedge core_clk);
    check(16'(spaf_host_model_i.got.size()), 16'(ex.size()));
    foreach (spaf_host_model_i.got[i]) check(spaf_host_model_i.got[i], ex[i]);
    spaf_host_model_i.got.delete();
  endtask

  task automatic rf_send(input logic [7:0] d, input logic l);
    @(negedge core_clk);
    rf_rx_valid = 1'b1;
    rf_rx_data = d;
    rf_rx_last = l;
    while (rf_rx_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    rf_rx_valid = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    spaf_host_model_i.tx_q.push_back(b);
    spaf_host_model_i.send(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {api_mode_en, spi_sel, command_mode, rf_tx_ready, rf_rx_valid, rf_rx_last} = 6'h00;
    {tx_status_valid, cmd_resp_valid, evt_reset, evt_assoc, evt_disassoc} = 5'h00;
    {tx_status_frame_id, tx_status_code, cmd_resp_frame_id, cmd_resp_status} = 32'h0;
    {rf_rx_data, rf_rx_len, rf_rx_src, packetization_timeout} = 40'h0;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    api_mode_en = 1'b1;
    foreach (rows[r]) begin
      @(negedge core_clk);
      spaf_host_model_i.slow = (r == 4);
      {evt_reset, evt_assoc, evt_disassoc} = 3'h1 << (3'h2 - rows[r].kind);
      tx_status_valid = (rows[r].kind == 3'h3);
      cmd_resp_valid = (rows[r].kind == 3'h4);
      {tx_status_frame_id, tx_status_code, cmd_resp_frame_id, cmd_resp_status} =
        {2{rows[r].a, rows[r].b}};
      @(negedge core_clk);
      {evt_reset, evt_assoc, evt_disassoc, tx_status_valid, cmd_resp_valid} = 5'h00;
      case (rows[r].kind)
        3'h3: fv = {24'h7e0003, spaf_pkg::TYPE_TX_STATUS, rows[r].a, rows[r].b, rows[r].sum, 8'h00};
        3'h4: fv = {24'h7e0003, spaf_pkg::TYPE_CMD_RESP, rows[r].a, rows[r].b, rows[r].sum, 8'h00};
        default: fv = {24'h7e0002, spaf_pkg::TYPE_EVENT, rows[r].a, rows[r].sum, 16'h0};
      endcase
      set_ex(fv, (rows[r].kind < 3'h3) ? 6 : 7);
      host_expect();
    end
    // Reset again mid-run in transparent mode.
    spaf_host_model_i.slow = 1'b0;
    api_mode_en = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    check({ser_tx_valid, rf_tx_valid, escape_detected, rx_overflow, rf_rx_ready}, 16'h01);
    rst = 1'b0;
    send_byte(8'h31);
    set_ex({8'h31, 56'h0}, 1);
    rf_take(1'b0);
    command_mode = 1'b1;
    send_byte(8'h32);
    repeat (20) @(negedge core_clk);
    check(rf_tx_valid, 1'b0);
    command_mode = 1'b0;
    // Idle gaps shorter than the timeout keep the three bytes in one packet.
    packetization_timeout = 8'h08;
    spaf_host_model_i.tx_q = '{8'h41, 8'h42, 8'h43};
    spaf_host_model_i.send(500);
    check(rf_tx_valid, 1'b0);
    set_ex({24'h414243, 40'h0}, 3);
    rf_take(1'b0);
    packetization_timeout = 8'hff;
    ovf_cnt = 0;
    ex.delete();
    for (int i = 0; i < 66; i++) spaf_host_model_i.tx_q.push_back(8'h50 + 8'(i));
    for (int i = 0; i < 64; i++) ex.push_back(8'h50 + 8'(i));
    spaf_host_model_i.send(0);
    repeat (2) @(negedge core_clk);
    check(rf_tx_valid, 1'b1);
    check(16'(ovf_cnt), 16'h2);
    rf_take(1'b0);
    guard_silence_time = 16'h0000;
    escape_sequence_character = 8'h2d;
    spaf_host_model_i.tx_q = '{8'h61, 8'h62, 8'h2d, 8'h2d, 8'h2d};
    spaf_host_model_i.send(0);
    @(negedge core_clk);
    check(escape_detected, 1'b1);
    set_ex({16'h6162, 48'h0}, 2);
    rf_take(1'b0);
    set_ex({16'hc1c2, 48'h0}, 2);
    rf_send(8'hc1, 1'b0);
    rf_send(8'hc2, 1'b1);
    host_expect();
    spi_sel = 1'b1;
    packetization_timeout = 8'h00;
    @(negedge core_clk);
    check(api_active, 1'b1);
    send_byte(8'h33);
    repeat (20) @(negedge core_clk);
    check(rf_tx_valid, 1'b0);
    rf_rx_len = 8'h01;
    rf_rx_src = 16'h1234;
    set_ex(64'h7e00049012_34aa7f, 8);
    rf_send(8'haa, 1'b1);
    host_expect();
    set_ex({24'h100141, 40'h0}, 3);
    spaf_host_model_i.frame(8'h10, 8'h01, 8'h41, 1'b0);
    rf_take(1'b0);
    set_ex({24'h084e49, 40'h0}, 3);
    spaf_host_model_i.frame(8'h08, 8'h4e, 8'h49, 1'b0);
    rf_take(1'b1);
    spaf_host_model_i.frame(8'h10, 8'h01, 8'h41, 1'b1);
    repeat (30) @(negedge core_clk);
    check(rf_tx_valid, 1'b0);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end
endmodule
